// >>> hw/acq_rec_ctrl.sv
`timescale 1ns/1ns
module acq_rec_ctrl import rec_pkg::*; #(
   parameter int          DW      = 16,
   parameter int          FIFO_AW = 4,
   parameter int          SWP_AW  = 4,
   parameter int          ADDR_W  = 24,
   parameter int          MAX_SWP = MAX_SWEEPS,
   parameter int unsigned MS_CYC  = MS_CYCLES
) (
   // Clock and reset
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_i,
   // User commands
   input  wire logic                   start_i,
   input  wire logic                   stop_i,
   // Configuration
   input  wire logic [1:0]             mode_i,
   input  wire logic                   dual_i,
   input  wire logic [ADDR_W-1:0]      hist_len_i,
   input  wire logic [31:0]            dur_ms_i,
   input  wire logic [SWP_AW:0]        sweep_len_i,
   input  wire logic [6:0]             pretrig_pct_i,
   input  wire logic [19:0]            delay_ms_i,
   // Asynchronous pins
   input  wire logic                   trig_i,
   input  wire logic                   store_full_i,
   // Sample input
   input  wire logic                   smp_valid_i,
   input  wire logic [DW-1:0]          smp_data_i,
   // Storage stream
   output logic                        rec_valid_o,
   input  wire logic                   rec_ready_i,
   output logic [1+ADDR_W+DW:0]        rec_data_o,
   // Status
   output logic                        rec_active_o,
   output logic                        suspended_o,
   output logic [17:0]                 sweep_cnt_o
);
   localparam int PW     = 2 + ADDR_W + DW;
   localparam int FDEPTH = 1 << FIFO_AW;
   localparam int SDEPTH = 1 << SWP_AW;

   typedef struct packed {
      rec_state_type      st;
      swp_state_type      sw;
      logic               t1;
      logic               t2;
      logic               t3;
      logic               f1;
      logic               f2;
      logic [1:0]         mode;
      logic               dual;
      logic [ADDR_W-1:0]  hist;
      logic [31:0]        dur;
      logic [SWP_AW:0]    slen;
      logic [SWP_AW:0]    pre_len;
      logic [19:0]        dly;
      logic [31:0]        tick;
      logic [31:0]        el;
      logic [19:0]        dcnt;
      logic [FIFO_AW-1:0] wp;
      logic [FIFO_AW-1:0] rp;
      logic [FIFO_AW:0]   fcnt;
      logic               note;
      logic [15:0]        ovr;
      logic [ADDR_W-1:0]  oaddr;
      logic [SWP_AW-1:0]  swp;
      logic [SWP_AW-1:0]  srd;
      logic [SWP_AW:0]    have;
      logic [SWP_AW:0]    rem;
      logic [SWP_AW:0]    tot;
      logic [SWP_AW:0]    sidx;
      logic [17:0]        scnt;
   } ctrl_type;

   ctrl_type           s;
   ctrl_type           n;
   logic [DW+1:0]      fifo_mem [FDEPTH];
   logic [DW-1:0]      swp_mem  [SDEPTH];
   logic               fifo_we;
   logic [DW+1:0]      fifo_wd;
   logic               swp_we;
   logic               trig;
   logic               cap;
   logic               fempty;
   logic               ffull;
   logic               pop;
   logic               swp_pop;
   logic               samp_in;
   logic               endc;
   logic               tick;
   logic               buf_valid;
   logic [PW-1:0]      buf_data;
   logic [SWP_AW:0]    h;
   logic [SWP_AW:0]    sl;
   logic [6:0]         pc;

   rec_stream_if #(.W(PW)) bin ();
   rec_stream_if #(.W(PW)) bout ();

   assign bin.valid    = buf_valid;
   assign bin.data     = buf_data;
   assign bout.ready   = rec_ready_i;
   assign rec_valid_o  = bout.valid;
   assign rec_data_o   = bout.data;
   assign rec_active_o = cap;
   assign suspended_o  = (s.st == ST_SUSP);
   assign sweep_cnt_o  = s.scnt;

   // Two-entry buffer absorbs storage stalls
   rec_skid #(.W(PW)) u_skid (
      .clk_i (core_clk_i),
      .rst_i (rst_i),
      .up    (bin.snk),
      .dn    (bout.src)
   );

   always_comb begin
      n       = s;
      fifo_we = 1'b0;
      fifo_wd = {TAG_SMP, smp_data_i};
      swp_we  = 1'b0;
      h       = s.have;
      sl      = '0;
      pc      = '0;
      // Pins pass two flops; third flop only for edge detect
      n.t1 = trig_i;
      n.t2 = s.t1;
      n.t3 = s.t2;
      n.f1 = store_full_i;
      n.f2 = s.f1;
      trig = s.t2 && !s.t3;
      tick = (s.tick == MS_CYC - 1);
      n.tick = tick ? 32'h0 : s.tick + 32'h1;
      cap    = (s.st != ST_IDLE);
      fempty = (s.fcnt == '0);
      ffull  = (s.fcnt == (FIFO_AW+1)'(FDEPTH));

      // Continuous words first, sweep words only when FIFO is empty
      buf_valid = !fempty || (s.sw == SW_DUMP);
      if (!fempty)
         buf_data = {fifo_mem[s.rp][DW+1:DW], s.oaddr, fifo_mem[s.rp][DW-1:0]};
      else
         buf_data = {TAG_SWP, ADDR_W'(s.sidx), swp_mem[s.srd]};
      pop     = !fempty && bin.ready;
      swp_pop = fempty && (s.sw == SW_DUMP) && bin.ready;
      if (pop) begin
         n.rp = s.rp + 1'b1;
         if (s.mode == MODE_CIRC && s.oaddr == s.hist - 1'b1) n.oaddr = '0;
         else n.oaddr = s.oaddr + 1'b1;
      end

      if (cap && tick) n.el = s.el + 32'h1;
      samp_in = (s.st == ST_RUN) && smp_valid_i && !ffull;

      unique case (s.st)
         ST_IDLE: begin
            if (start_i) begin
               // Configuration frozen for the whole recording
               sl        = (sweep_len_i == '0) ? (SWP_AW+1)'(1) : sweep_len_i;
               if (sl > (SWP_AW+1)'(SDEPTH)) sl = (SWP_AW+1)'(SDEPTH);
               pc        = (pretrig_pct_i > 7'(PCT_FULL)) ? 7'(PCT_FULL) : pretrig_pct_i;
               n.mode    = mode_i;
               n.dual    = dual_i;
               n.hist    = hist_len_i;
               n.dur     = dur_ms_i;
               n.slen    = sl;
               n.pre_len = (SWP_AW+1)'((32'(sl) * 32'(pc)) / 32'(PCT_FULL));
               n.dly     = (delay_ms_i > 20'(DELAY_MAX_MS)) ? 20'(DELAY_MAX_MS) : delay_ms_i;
               n.st      = ST_RUN;
               n.el      = '0;
               n.scnt    = '0;
               n.note    = 1'b0;
               n.oaddr   = '0;
               // Pre samples of an earlier recording must not count
               n.have    = '0;
            end
         end
         ST_RUN: begin
            if (smp_valid_i) begin
               if (ffull) begin
                  // Incoming sample is not recorded; queue kept intact
                  n.st   = ST_SUSP;
                  n.note = 1'b1;
                  n.ovr  = s.ovr + 16'h1;
               end else begin
                  fifo_we = 1'b1;
               end
            end
         end
         ST_SUSP: begin
            if (fempty) begin
               // Gap marker goes in ahead of the first resumed sample
               fifo_we = 1'b1;
               fifo_wd = {TAG_OVR, DW'(s.ovr)};
               n.note  = 1'b0;
               n.st    = ST_RUN;
            end
         end
      endcase

      endc = stop_i
           || (s.f2 && s.mode != MODE_CIRC)
           || (trig && !s.dual && (s.mode == MODE_CIRC || s.mode == MODE_TRIG))
           || (s.mode == MODE_TIMED && s.el >= s.dur);
      if (cap && endc) n.st = ST_IDLE;

      if (fifo_we) n.wp = s.wp + 1'b1;
      n.fcnt = s.fcnt + (FIFO_AW+1)'(fifo_we) - (FIFO_AW+1)'(pop);

      // Sweep engine
      unique case (s.sw)
         SW_ARM: begin
            if (samp_in && s.dual) begin
               swp_we = 1'b1;
               n.swp  = s.swp + 1'b1;
               h      = (s.have < s.pre_len) ? s.have + 1'b1 : s.pre_len;
               n.have = h;
            end
            if (cap && s.dual && trig && 32'(s.scnt) < MAX_SWP) begin
               if (s.dly != '0) begin
                  n.sw   = SW_DLY;
                  n.dcnt = s.dly;
               end else begin
                  // Only the pre-trigger samples really held are kept
                  n.srd  = n.swp - h[SWP_AW-1:0];
                  n.rem  = s.slen - s.pre_len;
                  n.tot  = h + (s.slen - s.pre_len);
                  n.sidx = '0;
                  // Nothing held and nothing to follow: no sweep at all
                  if (s.slen != s.pre_len) n.sw = SW_POST;
                  else if (h != '0) n.sw = SW_DUMP;
               end
            end
         end
         SW_DLY: begin
            if (tick) begin
               n.dcnt = s.dcnt - 20'h1;
               if (s.dcnt == 20'h1) begin
                  n.sw   = SW_POST;
                  n.srd  = s.swp;
                  n.rem  = s.slen;
                  n.tot  = s.slen;
                  n.sidx = '0;
               end
            end
         end
         SW_POST: begin
            if (samp_in) begin
               swp_we = 1'b1;
               n.swp  = s.swp + 1'b1;
               n.rem  = s.rem - 1'b1;
               if (s.rem == (SWP_AW+1)'(1)) n.sw = SW_DUMP;
            end
         end
         SW_DUMP: begin
            if (swp_pop) begin
               n.srd  = s.srd + 1'b1;
               n.sidx = s.sidx + 1'b1;
               if (s.sidx == s.tot - 1'b1) begin
                  n.sw   = SW_ARM;
                  n.have = '0;
                  n.scnt = s.scnt + 18'h1;
               end
            end
         end
      endcase
      // Recording ended mid-sweep: the unfinished sweep is dropped
      if (!cap && (s.sw == SW_DLY || s.sw == SW_POST)) begin
         n.sw   = SW_ARM;
         n.have = '0;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) s <= '0;
      else s <= n;
   end

   // Storage arrays carry no reset on purpose
   always_ff @(posedge core_clk_i) begin
      if (fifo_we) fifo_mem[s.wp] <= fifo_wd;
      if (swp_we) swp_mem[s.swp] <= smp_data_i;
   end

   AST_START: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s.st == ST_IDLE && start_i) |=> (s.st == ST_RUN))
      else $error("start did not begin capture");
   AST_MANUAL_FULL: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cap && s.mode == MODE_MANUAL && s.f2) |=> (s.st == ST_IDLE))
      else $error("manual capture kept going on full storage");
   AST_CIRC_WRAP: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (pop && s.mode == MODE_CIRC && s.oaddr == s.hist - 1'b1) |=> (s.oaddr == '0))
      else $error("circular address did not wrap");
   AST_TIMED_END: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cap && s.mode == MODE_TIMED && s.el >= s.dur) |=> (s.st == ST_IDLE))
      else $error("timed capture overran its duration");
   AST_TRIG_END: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cap && s.mode == MODE_TRIG && !s.dual && s.t2 && !s.t3) |=> (s.st == ST_IDLE))
      else $error("trigger did not stop capture");
   AST_SUSPEND: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s.st == ST_RUN && smp_valid_i && ffull && !endc) |=>
      (s.st == ST_SUSP && s.fcnt == $past(s.fcnt) - (FIFO_AW+1)'($past(pop))))
      else $error("full queue did not suspend");
   AST_RESUME_EMPTY: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($past(s.st) == ST_SUSP && s.st == ST_RUN) |-> ($past(s.fcnt) == '0))
      else $error("resumed before queue emptied");
   AST_NOTE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s.st == ST_SUSP && fempty && !endc) |=> (s.fcnt == (FIFO_AW+1)'(1) && !s.note))
      else $error("overrun note not written");
   AST_DELAY_POST: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($past(s.sw) == SW_DLY && s.sw == SW_POST) |-> (s.rem == s.slen && s.tot == s.slen))
      else $error("delayed sweep not all post-trigger");
   AST_SWEEP_MAX: assert property (@(posedge core_clk_i) disable iff (rst_i)
      32'(s.scnt) <= MAX_SWP)
      else $error("sweep count above limit");
   AST_PRIO: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!fempty && s.sw == SW_DUMP) |=> $stable(s.srd))
      else $error("sweep word sent ahead of continuous data");
   AST_LATCH: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cap && $past(cap)) |-> ($stable(s.mode) && $stable(s.pre_len) && $stable(s.dly)))
      else $error("configuration changed during capture");

   COV_SUSPEND: cover property (@(posedge core_clk_i) disable iff (rst_i)
      s.st == ST_RUN ##1 s.st == ST_SUSP);
   COV_RESUME: cover property (@(posedge core_clk_i) disable iff (rst_i)
      s.st == ST_SUSP ##1 s.st == ST_RUN);
   COV_DUMP_DONE: cover property (@(posedge core_clk_i) disable iff (rst_i)
      s.sw == SW_DUMP ##1 s.sw == SW_ARM);
   COV_DELAY: cover property (@(posedge core_clk_i) disable iff (rst_i)
      s.sw == SW_DLY ##1 s.sw == SW_POST);
endmodule

// >>> hw/rec_pkg.sv
package rec_pkg;

   // Clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Trigger delay and sweep limits
   localparam int DELAY_MAX_S   = 1000;
   localparam int DELAY_MAX_MS  = DELAY_MAX_S * 1000;
   localparam int MAX_SWEEPS    = 200000;
   localparam int PCT_FULL      = 100;

   // Word tags toward storage
   localparam logic [1:0] TAG_SMP = 2'h0;
   localparam logic [1:0] TAG_OVR = 2'h1;
   localparam logic [1:0] TAG_SWP = 2'h2;

   typedef enum logic [1:0] {
      MODE_MANUAL = 2'h0,
      MODE_CIRC   = 2'h1,
      MODE_TIMED  = 2'h2,
      MODE_TRIG   = 2'h3
   } rec_mode_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN  = 2'h1,
      ST_SUSP = 2'h3
   } rec_state_type;

   typedef enum logic [1:0] {
      SW_ARM  = 2'h0,
      SW_DLY  = 2'h1,
      SW_POST = 2'h3,
      SW_DUMP = 2'h2
   } swp_state_type;

endpackage

// >>> hw/rec_stream_if.sv
`timescale 1ns/1ns
interface rec_stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// >>> hw/rec_skid.sv
`timescale 1ns/1ns
module rec_skid #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic   clk_i,
   input wire logic   rst_i,
   // Streams
   rec_stream_if.snk  up,
   rec_stream_if.src  dn
);
   typedef struct packed {
      logic [W-1:0] e0;
      logic [W-1:0] e1;
      logic [1:0]   cnt;
   } skid_type;

   skid_type s;
   skid_type n;
   logic     push;
   logic     pop;

   assign up.ready = (s.cnt != 2'h2);
   assign dn.valid = (s.cnt != 2'h0);
   assign dn.data  = s.e0;

   always_comb begin
      n    = s;
      push = up.valid && up.ready;
      pop  = dn.valid && dn.ready;
      unique case ({push, pop})
         2'b10: begin
            if (s.cnt == 2'h0) n.e0 = up.data;
            else n.e1 = up.data;
            n.cnt = s.cnt + 2'h1;
         end
         2'b01: begin
            n.e0  = s.e1;
            n.cnt = s.cnt - 2'h1;
         end
         2'b11: begin
            if (s.cnt == 2'h1) n.e0 = up.data;
            else begin
               n.e0 = s.e1;
               n.e1 = up.data;
            end
         end
         2'b00: ;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) s <= '0;
      else s <= n;
   end

   // Stalled receiver keeps its word
   AST_SKID_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (dn.valid && !dn.ready) |=> (dn.valid && $stable(dn.data)))
      else $error("buffer lost a stalled word");
   COV_SKID_FULL: cover property (@(posedge clk_i) disable iff (rst_i) s.cnt == 2'h2);
endmodule

// >>> sim/rec_store_model.sv
`timescale 1ns/1ns
module rec_store_model #(
   parameter int W = 18
) (
   // Clock
   input  wire logic         clk_i,
   // Behaviour control
   input  wire logic         stall_i,
   input  wire logic         slow_i,
   // Storage stream
   input  wire logic         valid_i,
   input  wire logic [W-1:0] data_i,
   output logic              ready_o
);
   logic [W-1:0] got[$];

   // Word taken only where valid and ready meet at an edge
   always @(posedge clk_i) begin
      if (valid_i && ready_o) begin
         got.push_back(data_i);
      end
      // Slow answer accepts every other cycle
      #1 ready_o <= !stall_i && !(slow_i && ready_o);
   end
endmodule

// >>> sim/acq_rec_ctrl_tb.sv
`timescale 1ns/1ns
module acq_rec_ctrl_tb;
   import rec_pkg::*;
   localparam int DW = 8;
   localparam int AW = 8;
   localparam int W  = DW + AW + 2;
   logic          core_clk_i = 0, rst_i = 1, start_i = 0, stop_i = 0;
   logic          dual_i = 0, trig_i = 0, store_full_i = 0, smp_valid_i = 0;
   logic [1:0]    mode_i = 2'h0;
   logic [AW-1:0] hist_len_i = 8'h04;
   logic [31:0]   dur_ms_i = 32'h2;
   logic [4:0]    sweep_len_i = 5'h04;
   logic [6:0]    pretrig_pct_i = 7'h32;
   logic [19:0]   delay_ms_i = 20'h0;
   logic [DW-1:0] smp_data_i = 8'h00;
   logic          rec_valid_o, rec_ready_i, rec_active_o, suspended_o;
   logic [W-1:0]  rec_data_o;
   logic [17:0]   sweep_cnt_o;
   logic          stall = 0, slow = 0;
   int            n_fail = 0, check_count = 0, cyc = 0;

   always #5 core_clk_i = ~core_clk_i;

   acq_rec_ctrl #(.DW(DW), .FIFO_AW(4), .SWP_AW(4), .ADDR_W(AW), .MAX_SWP(2), .MS_CYC(10)) dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i), .stop_i(stop_i), .mode_i(mode_i),
      .dual_i(dual_i), .hist_len_i(hist_len_i), .dur_ms_i(dur_ms_i), .sweep_len_i(sweep_len_i),
      .pretrig_pct_i(pretrig_pct_i), .delay_ms_i(delay_ms_i), .trig_i(trig_i),
      .store_full_i(store_full_i), .smp_valid_i(smp_valid_i), .smp_data_i(smp_data_i),
      .rec_valid_o(rec_valid_o), .rec_ready_i(rec_ready_i), .rec_data_o(rec_data_o),
      .rec_active_o(rec_active_o), .suspended_o(suspended_o), .sweep_cnt_o(sweep_cnt_o));

   rec_store_model #(.W(W)) sink (
      .clk_i(core_clk_i), .stall_i(stall), .slow_i(slow), .valid_i(rec_valid_o),
      .data_i(rec_data_o), .ready_o(rec_ready_i));

   function logic [1:0] tg(input logic [W-1:0] w);
      return w[W-1 -: 2];
   endfunction
   function logic [AW-1:0] adr(input logic [W-1:0] w);
      return w[DW +: AW];
   endfunction

   task summarize();
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task go(input logic [1:0] m, input logic d);
      mode_i = m;
      dual_i = d;
      // Let the pin synchronisers settle from the last test
      tick(2);
      sink.got.delete();
      start_i = 1;
      tick(1);
      start_i = 0;
   endtask

   task send(input int n, input int gap, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         smp_valid_i = 1;
         smp_data_i = base + 8'(i);
         tick(1);
         if (gap > 0) begin
            smp_valid_i = 0;
            tick(gap);
         end
      end
      smp_valid_i = 0;
   endtask

   task pulse_stop();
      stop_i = 1;
      tick(1);
      stop_i = 0;
   endtask

   task pulse_trig();
      trig_i = 1;
      tick(2);
      trig_i = 0;
   endtask

   // Bounded wait for the end of capture
   task wait_end(input int lim);
      int k;
      k = 0;
      while (rec_active_o !== 1'b0 && k < lim) begin
         tick(1);
         k++;
      end
      check(k < lim, 1);
   endtask

   task t_manual();
      slow = 1;
      go(MODE_MANUAL, 0);
      check(rec_active_o, 1);
      send(3, 1, 8'h10);
      tick(8);
      check(sink.got.size(), 3);
      for (int i = 0; i < 3; i++) begin
         check(tg(sink.got[i]), TAG_SMP);
         check(sink.got[i][DW-1:0], 8'h10 + i);
      end
      pulse_stop();
      wait_end(4);
      slow = 0;
      $display("Test manual done");
   endtask

   // Mode changed after start must not take effect
   task t_full_latch();
      go(MODE_MANUAL, 0);
      mode_i = MODE_CIRC;
      tick(2);
      store_full_i = 1;
      wait_end(8);
      store_full_i = 0;
      $display("Test storage full done");
   endtask

   task t_timed();
      dur_ms_i = 32'h2;
      go(MODE_TIMED, 0);
      tick(5);
      check(rec_active_o, 1);
      wait_end(40);
      dur_ms_i = 32'h3E8;
      go(MODE_TIMED, 0);
      tick(3);
      store_full_i = 1;
      wait_end(8);
      store_full_i = 0;
      $display("Test timed done");
   endtask

   task t_circ_trig();
      go(MODE_CIRC, 0);
      send(6, 1, 8'h20);
      tick(6);
      check(sink.got.size(), 6);
      for (int i = 0; i < 6; i++) begin
         check(adr(sink.got[i]), i % 4);
      end
      pulse_trig();
      wait_end(8);
      go(MODE_TRIG, 0);
      tick(3);
      pulse_trig();
      wait_end(8);
      $display("Test circular and trigger done");
   endtask

   task t_overrun();
      int k, n;
      stall = 1;
      go(MODE_MANUAL, 0);
      send(24, 0, 8'h40);
      check(suspended_o, 1);
      stall = 0;
      tick(2);
      check(suspended_o, 1);
      k = 0;
      while (suspended_o !== 1'b0 && k < 200) begin
         tick(1);
         k++;
      end
      check(k < 200, 1);
      send(2, 1, 8'h80);
      tick(8);
      n = sink.got.size();
      check(n, 21);
      check(tg(sink.got[n-3]), TAG_OVR);
      check(sink.got[n-3][DW-1:0], 8'h01);
      check(sink.got[n-1][DW-1:0], 8'h81);
      for (int i = 0; i < n - 3; i++) begin
         check(sink.got[i][DW-1:0], 8'h40 + i);
      end
      pulse_stop();
      wait_end(4);
      $display("Test overrun done");
   endtask

   task t_sweep();
      int n;
      go(MODE_MANUAL, 1);
      for (int s = 0; s < 3; s++) begin
         send(6, 3, 8'(s * 16));
         pulse_trig();
         send(8, 3, 8'(s * 16 + 8));
         tick(20);
      end
      check(sweep_cnt_o, 2);
      n = 0;
      foreach (sink.got[i]) n += (tg(sink.got[i]) == TAG_SWP);
      check(n, 8);
      pulse_stop();
      wait_end(4);
      // Trigger after one sample: pre part holds that one only
      go(MODE_MANUAL, 1);
      send(1, 1, 8'h70);
      pulse_trig();
      tick(2);
      send(6, 1, 8'h78);
      tick(20);
      n = 0;
      foreach (sink.got[i]) begin
         if (tg(sink.got[i]) == TAG_SWP) begin
            if (n == 0) check(sink.got[i][DW-1:0], 8'h70);
            n++;
         end
      end
      check(n, 3);
      pulse_stop();
      wait_end(4);
      // Delayed sweep holds only samples after the trigger
      delay_ms_i = 20'h1;
      go(MODE_MANUAL, 1);
      send(6, 1, 8'h50);
      pulse_trig();
      send(20, 1, 8'h60);
      tick(20);
      n = 0;
      foreach (sink.got[i]) begin
         if (tg(sink.got[i]) == TAG_SWP) begin
            n++;
            check(sink.got[i][DW-1:0] >= 8'h60, 1);
         end
      end
      check(n, 4);
      pulse_stop();
      wait_end(4);
      $display("Test sweep done");
   endtask

   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("Error at %0t: timeout", $time);
         summarize();
      end
   end

   initial begin
      tick(4);
      check(rec_valid_o, 0);
      check(rec_active_o, 0);
      check(suspended_o, 0);
      check(sweep_cnt_o, 0);
      check(rec_data_o, 0);
      tick(1);
      rst_i = 0;
      tick(1);
      t_manual();
      t_full_latch();
      t_timed();
      t_circ_trig();
      t_overrun();
      t_sweep();
      summarize();
   end
endmodule
